// [logic/tap_params.svh]
// constants of the boundary-scan test access port controller
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define TAP_IR_W        8
`define TAP_IR_RST      8'hFF
`define TAP_IR_STATUS   8'h81
`define TAP_BSR_W       38
`define TAP_BSR_RST     38'h30_0000_0000
`define TAP_BCR_W       11
`define TAP_BCR_RST     11'h002
`define TAP_RST_STEPS   3'h5

// supported opcodes, parity bit included
`define TAP_OP_EXT_TEST 8'h00
`define TAP_OP_SAMPLE   8'h82
`define TAP_OP_INT_TEST 8'h03
`define TAP_OP_HIGH_Z   8'h06
`define TAP_OP_CLAMP    8'h87
`define TAP_OP_RUN_TEST 8'h09
`define TAP_OP_RD_NORM  8'h0A
`define TAP_OP_RD_TEST  8'h8B
`define TAP_OP_CELL_TST 8'h0C
`define TAP_OP_TOGGLE   8'h8D
`define TAP_OP_CTRL_SCN 8'h8E

`endif

// [logic/tap_pkg.sv]
// types and decode functions of the test access port controller
`include "tap_params.svh"
package tap_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
        TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } tap_state_t;

    typedef enum logic [1:0] {
        TAP_DR_BYPASS, TAP_DR_BOUNDARY, TAP_DR_CONTROL
    } tap_dr_t;

    // exact match on all eight bits, so a bad parity bit falls to bypass
    function automatic tap_dr_t tap_dr_sel(input logic [7:0] op);
        case (op)
            `TAP_OP_EXT_TEST, `TAP_OP_SAMPLE, `TAP_OP_INT_TEST, `TAP_OP_RD_NORM,
            `TAP_OP_RD_TEST, `TAP_OP_CELL_TST: tap_dr_sel = TAP_DR_BOUNDARY;
            `TAP_OP_CTRL_SCN:                  tap_dr_sel = TAP_DR_CONTROL;
            default:                           tap_dr_sel = TAP_DR_BYPASS;
        endcase
    endfunction

    function automatic logic tap_is_test(input logic [7:0] op);
        case (op)
            `TAP_OP_EXT_TEST, `TAP_OP_INT_TEST, `TAP_OP_HIGH_Z, `TAP_OP_CLAMP,
            `TAP_OP_RUN_TEST, `TAP_OP_RD_TEST, `TAP_OP_TOGGLE: tap_is_test = 1'b1;
            default:                                           tap_is_test = 1'b0;
        endcase
    endfunction

endpackage

// [logic/tap_sync.sv]
// three-stage level synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ns
module tap_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level in and out
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // output follows only a settled level
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            q_o <= s3_ff;
        end
    end
endmodule // tap_sync

// [logic/tap_fsm.sv]
// sixteen-state test access port controller
`timescale 1ns/1ns
module tap_fsm
    import tap_pkg::*;
(
    // link clock and reset
    input  wire logic tck_i,
    input  wire logic rst_i,
    // mode select
    input  wire logic tms_i,
    output tap_state_t state_o
);
    tap_state_t nxt_state;

    // standard transition graph, all-ones TMS walks back to reset
    always_comb begin
        unique case (state_o)
            TAP_RESET:  nxt_state = tms_i ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   nxt_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: nxt_state = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: nxt_state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  nxt_state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: nxt_state = tms_i ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: nxt_state = tms_i ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: nxt_state = tms_i ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: nxt_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: nxt_state = tms_i ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: nxt_state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  nxt_state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: nxt_state = tms_i ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: nxt_state = tms_i ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: nxt_state = tms_i ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: nxt_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // one step per rising edge, power-up lands in reset
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            state_o <= TAP_RESET;
        end else begin
            state_o <= nxt_state;
        end
    end
endmodule // tap_fsm

// [logic/tap_top.sv]
// boundary-scan port: controller, instruction and data registers, TDO driver
`timescale 1ns/1ns
`include "tap_params.svh"
module tap_top
    import tap_pkg::*;
(
    // system clock and power-up reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   sys_rst_i,
    // test port, link clock domain
    input  wire logic                   tck_i,
    input  wire logic                   tms_i,
    input  wire logic                   tdi_i,
    output logic                        tdo_o,
    output logic                        tdo_oe_n_o,
    // boundary pin values presented for capture, link clock domain
    input  wire logic [`TAP_BSR_W-1:0]  bsr_capture_i,
    // latched test registers, link clock domain
    output logic [`TAP_IR_W-1:0]        instruction_o,
    output logic [`TAP_BSR_W-1:0]       bsr_latch_o,
    output logic [`TAP_BCR_W-1:0]       bcr_latch_o,
    // mode levels, system clock domain
    output logic                        test_mode_o,
    output logic                        run_test_o
);

    // ****************************************
    // controller
    // ****************************************

    tap_state_t                 state;
    tap_dr_t                    dr_sel;
    logic [`TAP_IR_W-1:0]       ir_shift_ff;
    logic [`TAP_BSR_W-1:0]      bsr_shift_ff;
    logic [`TAP_BCR_W-1:0]      bcr_shift_ff;
    logic                       byp_shift_ff;
    logic                       test_mode_ff;
    logic                       run_op_ff;
    logic                       nxt_tdo;

    tap_fsm u_fsm (
        .tck_i   (tck_i),
        .rst_i   (sys_rst_i),
        .tms_i   (tms_i),
        .state_o (state)
    );

    // only one data register sits in the path per scan
    assign dr_sel = tap_dr_sel(instruction_o);

    // ****************************************
    // shift stages, sampled on rising TCK
    // ****************************************

    // instruction stage: status on capture, LSB first out
    always_ff @(posedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ir_shift_ff <= `TAP_IR_RST;
        end else begin
            unique case (state)
                TAP_RESET:  ir_shift_ff <= `TAP_IR_RST;
                TAP_CAP_IR: ir_shift_ff <= `TAP_IR_STATUS;
                TAP_SH_IR:  ir_shift_ff <= {tdi_i, ir_shift_ff[`TAP_IR_W-1:1]};
                default:    ir_shift_ff <= ir_shift_ff;
            endcase
        end
    end

    // boundary stage: scan order TDI, bit 37 down to bit 0, TDO
    always_ff @(posedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bsr_shift_ff <= `TAP_BSR_RST;
        end else if (state == TAP_RESET) begin
            bsr_shift_ff <= `TAP_BSR_RST;
        end else if (dr_sel == TAP_DR_BOUNDARY) begin
            if (state == TAP_CAP_DR) begin
                bsr_shift_ff <= bsr_capture_i;
            end else if (state == TAP_SH_DR) begin
                bsr_shift_ff <= {tdi_i, bsr_shift_ff[`TAP_BSR_W-1:1]};
            end
        end
    end

    // control stage keeps its contents through capture
    always_ff @(posedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bcr_shift_ff <= `TAP_BCR_RST;
        end else if (state == TAP_RESET) begin
            bcr_shift_ff <= `TAP_BCR_RST;
        end else if (dr_sel == TAP_DR_CONTROL && state == TAP_SH_DR) begin
            bcr_shift_ff <= {tdi_i, bcr_shift_ff[`TAP_BCR_W-1:1]};
        end
    end

    // bypass is a lone shift bit with no latch behind it
    always_ff @(posedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            byp_shift_ff <= 1'b0;
        end else if (dr_sel == TAP_DR_BYPASS) begin
            if (state == TAP_CAP_DR) begin
                byp_shift_ff <= 1'b0;
            end else if (state == TAP_SH_DR) begin
                byp_shift_ff <= tdi_i;
            end
        end
    end

    // ****************************************
    // latches and outputs, changed on falling TCK
    // ****************************************

    // instruction latch and mode; reset state forces bypass and normal mode
    always_ff @(negedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            instruction_o <= `TAP_IR_RST;
            test_mode_ff  <= 1'b0;
        end else if (state == TAP_RESET) begin
            instruction_o <= `TAP_IR_RST;
            test_mode_ff  <= 1'b0;
        end else if (state == TAP_UPD_IR) begin
            instruction_o <= ir_shift_ff;
            test_mode_ff  <= tap_is_test(ir_shift_ff);
        end
    end

    // data latches follow the shift stage only when selected
    always_ff @(negedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bsr_latch_o <= `TAP_BSR_RST;
            bcr_latch_o <= `TAP_BCR_RST;
        end else if (state == TAP_RESET) begin
            bsr_latch_o <= `TAP_BSR_RST;
            bcr_latch_o <= `TAP_BCR_RST;
        end else if (state == TAP_UPD_DR) begin
            if (dr_sel == TAP_DR_BOUNDARY) begin
                bsr_latch_o <= bsr_shift_ff;
            end
            if (dr_sel == TAP_DR_CONTROL) begin
                bcr_latch_o <= bcr_shift_ff;
            end
        end
    end

    // control-register operations only run while idling under run-test
    always_ff @(negedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_op_ff <= 1'b0;
        end else begin
            run_op_ff <= (state == TAP_IDLE) && (instruction_o == `TAP_OP_RUN_TEST);
        end
    end

    // serial output picks the LSB of whichever register is in the path
    always_comb begin
        nxt_tdo = byp_shift_ff;
        if (state == TAP_SH_IR) begin
            nxt_tdo = ir_shift_ff[0];
        end else if (dr_sel == TAP_DR_BOUNDARY) begin
            nxt_tdo = bsr_shift_ff[0];
        end else if (dr_sel == TAP_DR_CONTROL) begin
            nxt_tdo = bcr_shift_ff[0];
        end
    end

    // driver on the falling edge gives the tester half a cycle of setup
    always_ff @(negedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tdo_o      <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end else if (state == TAP_SH_DR || state == TAP_SH_IR) begin
            tdo_o      <= nxt_tdo;
            tdo_oe_n_o <= 1'b0;
        end else begin
            tdo_oe_n_o <= 1'b1;
        end
    end

    // ****************************************
    // crossing into the system clock
    // ****************************************

    // levels only; TCK may stop, so the system side just follows the last value
    tap_sync u_sync_mode (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   (test_mode_ff),
        .q_o   (test_mode_o)
    );

    tap_sync u_sync_run (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   (run_op_ff),
        .q_o   (run_test_o)
    );

    // ****************************************
    // checks
    // ****************************************

    default clocking cb_tck @(posedge tck_i);
    endclocking
    default disable iff (sys_rst_i);

    logic [2:0] tms_run_ff;

    // counts consecutive high TMS samples, saturating
    always_ff @(posedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tms_run_ff <= 3'h0;
        end else if (!tms_i) begin
            tms_run_ff <= 3'h0;
        end else if (tms_run_ff != `TAP_RST_STEPS) begin
            tms_run_ff <= tms_run_ff + 3'h1;
        end
    end

    chk_reset_walk: assert property (tms_run_ff == `TAP_RST_STEPS |-> state == TAP_RESET)
        else $error("five high TMS samples did not reach reset");
    chk_select_leave: assert property ((state == TAP_SEL_DR || state == TAP_SEL_IR) |=>
        (state != $past(state)))
        else $error("scan-select state held for two cycles");
    chk_ir_status: assert property (state == TAP_CAP_IR |=> ir_shift_ff == `TAP_IR_STATUS)
        else $error("capture-ir did not load the status pattern");
    chk_ir_reset: assert property (state == TAP_RESET && $past(state) == TAP_RESET |->
        instruction_o == `TAP_IR_RST)
        else $error("instruction not all ones in reset state");
    chk_ir_shift: assert property (state == TAP_SH_IR |=>
        ir_shift_ff == {$past(tdi_i), $past(ir_shift_ff[`TAP_IR_W-1:1])})
        else $error("instruction stage did not shift by one");
    chk_bypass_zero: assert property (state == TAP_CAP_DR && dr_sel == TAP_DR_BYPASS |=>
        !byp_shift_ff)
        else $error("bypass did not capture zero");
    chk_pause_hold: assert property (state == TAP_PAU_DR |=>
        bsr_shift_ff == $past(bsr_shift_ff) && bcr_shift_ff == $past(bcr_shift_ff))
        else $error("pause changed a data register");
    chk_bcr_capture: assert property (state == TAP_CAP_DR |=> bcr_shift_ff == $past(bcr_shift_ff))
        else $error("control register changed on capture");
    chk_tdo_float: assert property (state != TAP_SH_DR && state != TAP_SH_IR |-> tdo_oe_n_o)
        else $error("TDO driven outside shift");
    chk_tdo_drive: assert property ((state == TAP_SH_DR || state == TAP_SH_IR) |-> !tdo_oe_n_o)
        else $error("TDO not driven in shift");
    chk_run_idle: assert property (run_op_ff |-> state == TAP_IDLE)
        else $error("run-test operation outside idle");

    // latches move only on an update or reset falling edge
    chk_bsr_latch_upd: assert property ($changed(bsr_latch_o) |->
        state == TAP_UPD_DR || state == TAP_RESET)
        else $error("boundary latch changed outside update");

    chk_bcr_latch_upd: assert property ($changed(bcr_latch_o) |->
        state == TAP_UPD_DR || state == TAP_RESET)
        else $error("control latch changed outside update");

    chk_instr_update: assert property ($changed(instruction_o) |->
        state == TAP_UPD_IR || state == TAP_RESET)
        else $error("instruction changed outside update");

    chk_instr_load: assert property (state == TAP_UPD_IR |-> instruction_o == ir_shift_ff)
        else $error("update-ir did not latch the shifted opcode");

    // a settled reset state keeps boundary and control stages, latches and mode at power-up values
    chk_data_reset: assert property (state == TAP_RESET && $past(state) == TAP_RESET |->
        bsr_shift_ff == `TAP_BSR_RST && bcr_shift_ff == `TAP_BCR_RST &&
        bsr_latch_o == `TAP_BSR_RST && bcr_latch_o == `TAP_BCR_RST)
        else $error("data register not at reset value in reset state");

    chk_mode_reset: assert property (state == TAP_RESET && $past(state) == TAP_RESET |->
        !test_mode_ff && !run_op_ff)
        else $error("test mode active in reset state");

    // data stages capture by selection and shift one place per rising edge
    chk_bsr_capture: assert property (state == TAP_CAP_DR && dr_sel == TAP_DR_BOUNDARY |=>
        bsr_shift_ff == $past(bsr_capture_i))
        else $error("boundary stage did not capture the pin values");

    chk_bsr_shift: assert property (state == TAP_SH_DR && dr_sel == TAP_DR_BOUNDARY |=>
        bsr_shift_ff == {$past(tdi_i), $past(bsr_shift_ff[`TAP_BSR_W-1:1])})
        else $error("boundary stage did not shift by one");

    chk_byp_shift: assert property (state == TAP_SH_DR && dr_sel == TAP_DR_BYPASS |=>
        byp_shift_ff == $past(tdi_i))
        else $error("bypass bit did not follow TDI");

    // one register in the path per scan; pause keeps the instruction stage
    chk_ir_pause: assert property (state == TAP_PAU_IR |=> $stable(ir_shift_ff))
        else $error("pause changed the instruction stage");

    chk_ir_apart: assert property (state == TAP_SH_DR |=> $stable(ir_shift_ff))
        else $error("instruction stage moved in a data scan");

    chk_dr_apart: assert property (state == TAP_SH_IR |=>
        $stable(bsr_shift_ff) && $stable(bcr_shift_ff) && $stable(byp_shift_ff))
        else $error("data stage moved in an instruction scan");

    // serial output carries the LSB of the instruction or boundary stage, whichever is in the path
    chk_tdo_ir_lsb: assert property (state == TAP_SH_IR |-> tdo_o == ir_shift_ff[0])
        else $error("TDO not the instruction stage LSB");

    chk_tdo_bsr_lsb: assert property (state == TAP_SH_DR && dr_sel == TAP_DR_BOUNDARY |->
        tdo_o == bsr_shift_ff[0])
        else $error("TDO not the boundary stage LSB");

    cov_ir_update: cover property (state == TAP_SH_IR ##1 state == TAP_EX1_IR ##1 state == TAP_UPD_IR);
    cov_dr_pause: cover property (state == TAP_PAU_DR ##1 state == TAP_EX2_DR ##1 state == TAP_SH_DR);
    cov_run_test: cover property (run_op_ff ##1 run_op_ff);
    cov_reset_walk: cover property (state == TAP_UPD_DR ##1 tms_run_ff == `TAP_RST_STEPS);
    cov_bsr_update: cover property (state == TAP_UPD_DR && dr_sel == TAP_DR_BOUNDARY);

endmodule // tap_top

// [testbench/tap_tester.sv]
// tester model of the external boundary-scan bus controller: makes TCK, drives TMS and TDI, reads TDO
`timescale 1ns/1ns
module tap_tester (
    // test port towards the device
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_n_i
);
    localparam int HALF = 80;

    logic last_tdo;

    // tck stands low between frames, tms and tdi rest high like their pull-ups
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        last_tdo = 1'b0;
    end

    // ****************************************
    // bus cycles
    // ****************************************
    // one tck period; a released tdo reads as the inverse of its last driven level
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #(HALF - 1) tck_o = 1'b1;
        #HALF tck_o = 1'b0;
        #1;
        if (!tdo_oe_n_i) last_tdo = tdo_i;
        tdo = tdo_oe_n_i ? ~last_tdo : tdo_i;
    endtask

    // leave Test-Logic-Reset through Run-Test/Idle before any scan
    task automatic idle();
        logic t;
        step(1'b0, 1'b1, t);
    endtask

    // scan from Run-Test/Idle back to it, lsb first; optional pause after bit pause_at-1
    task automatic scan(input logic ir, input int n, input logic [37:0] din, input int pause_at,
                        output logic [37:0] dout, output logic oe_ok);
        logic t;
        int   i;
        dout = '0;
        oe_ok = 1'b1;
        step(1'b1, 1'b1, t);
        if (ir) begin
            step(1'b1, 1'b1, t);
        end
        step(1'b0, 1'b1, t);
        step(1'b0, 1'b1, t);
        for (i = 0; i < n; i++) begin
            dout[i] = t;
            if (tdo_oe_n_i !== 1'b0) oe_ok = 1'b0;
            step(i == n - 1 || i == pause_at - 1, din[i], t);
            if (i == pause_at - 1 && i != n - 1) begin
                // exit1, three pause cycles, exit2, back into shift
                if (tdo_oe_n_i !== 1'b1) oe_ok = 1'b0;
                repeat (3) step(1'b0, 1'b0, t);
                step(1'b1, 1'b0, t);
                step(1'b0, 1'b0, t);
            end
        end
        if (tdo_oe_n_i !== 1'b1) oe_ok = 1'b0;
        step(1'b1, 1'b1, t);
        step(1'b0, 1'b1, t);
    endtask
endmodule // tap_tester

// [testbench/testbench.sv]
// self-checking bench of the boundary-scan port with the tester model on the test port
`timescale 1ns/1ns
`include "tap_params.svh"
module testbench;
    // ****************************************
    // signals
    // ****************************************
    logic                  ref_clk_i;
    logic                  sys_rst_i;
    logic                  tck;
    logic                  tms;
    logic                  tdi;
    logic                  tdo;
    logic                  tdo_oe_n;
    logic [`TAP_BSR_W-1:0] bsr_capture;
    logic [`TAP_IR_W-1:0]  instruction;
    logic [`TAP_BSR_W-1:0] bsr_latch;
    logic [`TAP_BCR_W-1:0] bcr_latch;
    logic                  test_mode;
    logic                  run_test;
    logic [`TAP_BSR_W-1:0] bsr_exp;
    logic [`TAP_BCR_W-1:0] bcr_exp;
    int                    mismatches = 0;
    int                    n_checks = 0;
    int                    cycles = 0;
    // rows: opcode, expected test mode, register kind (0 bypass, 1 boundary, 2 control)
    logic [10:0]           rows [15] = '{
        {8'h00, 1'b1, 2'h1}, {8'h82, 1'b0, 2'h1}, {8'h03, 1'b1, 2'h1}, {8'h06, 1'b1, 2'h0},
        {8'h87, 1'b1, 2'h0}, {8'h09, 1'b1, 2'h0}, {8'h0A, 1'b0, 2'h1}, {8'h8B, 1'b1, 2'h1},
        {8'h0C, 1'b0, 2'h1}, {8'h8D, 1'b1, 2'h0}, {8'h8E, 1'b0, 2'h2}, {8'h81, 1'b0, 2'h0},
        {8'h05, 1'b0, 2'h0}, {8'h80, 1'b0, 2'h0}, {8'hFF, 1'b0, 2'h0}};

    // system clock, 100 MHz
    initial ref_clk_i = 1'b0;
    always #5 ref_clk_i = ~ref_clk_i;

    tap_top dut (
        .ref_clk_i     (ref_clk_i),
        .sys_rst_i     (sys_rst_i),
        .tck_i         (tck),
        .tms_i         (tms),
        .tdi_i         (tdi),
        .tdo_o         (tdo),
        .tdo_oe_n_o    (tdo_oe_n),
        .bsr_capture_i (bsr_capture),
        .instruction_o (instruction),
        .bsr_latch_o   (bsr_latch),
        .bcr_latch_o   (bcr_latch),
        .test_mode_o   (test_mode),
        .run_test_o    (run_test)
    );

    tap_tester tst (
        .tck_o      (tck),
        .tms_o      (tms),
        .tdi_o      (tdi),
        .tdo_i      (tdo),
        .tdo_oe_n_i (tdo_oe_n)
    );

    // ****************************************
    // checks and reporting
    // ****************************************
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hung handshake would stop tck for good, so count system clocks instead
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            $display("mismatch at %0t: run too long", $time);
            wrap_up();
        end
    end

    // hold reset 20 cycles; the reset values must already show while it is held
    task automatic do_reset();
        @(negedge ref_clk_i);
        sys_rst_i = 1'b1;
        repeat (20) @(negedge ref_clk_i);
        check(instruction === `TAP_IR_RST && tdo_oe_n === 1'b1, "reset instruction");
        check(bsr_latch === `TAP_BSR_RST && bcr_latch === `TAP_BCR_RST, "reset latches");
        check(test_mode === 1'b0 && run_test === 1'b0, "reset mode levels");
        sys_rst_i = 1'b0;
        bsr_exp = `TAP_BSR_RST;
        bcr_exp = `TAP_BCR_RST;
    endtask

    // load an opcode by instruction scan and check its effect back in Run-Test/Idle
    task automatic ir_load(input logic [7:0] op, input logic md, input int pause_at);
        logic [37:0] dout;
        logic        ok;
        tst.scan(1'b1, 8, {30'h0, op}, pause_at, dout, ok);
        check(dout[7:0] === `TAP_IR_STATUS, "status pattern");
        check(ok, "tdo enable in instruction scan");
        check(instruction === op, "current instruction");
        check(test_mode === md && tdo_oe_n === 1'b1, "mode level or idle tdo");
        // the run level rises only once idle is reached, then needs a few system clocks to cross
        repeat (6) @(negedge ref_clk_i);
        check(run_test === (op == `TAP_OP_RUN_TEST), "run test level");
    endtask

    // data scan of the register picked by the current instruction
    task automatic dr_scan(input logic [1:0] kd, input logic [37:0] din, input int pause_at);
        logic [37:0] dout;
        logic        ok;
        int          n;
        n = (kd == 2'h1) ? 38 : (kd == 2'h2) ? 11 : 2;
        @(negedge ref_clk_i);
        bsr_capture = din ^ 38'h15_A5C3_0F0F;
        tst.scan(1'b0, n, din, pause_at, dout, ok);
        check(ok, "tdo enable in data scan");
        if (kd == 2'h1) begin
            check(dout === bsr_capture, "boundary capture");
            bsr_exp = din;
        end else if (kd == 2'h2) begin
            check(dout[10:0] === bcr_exp, "control register kept");
            bcr_exp = din[10:0];
        end else begin
            check(dout[1:0] === {din[0], 1'b0}, "bypass capture or length");
        end
        check(bsr_latch === bsr_exp && bcr_latch === bcr_exp, "data latches");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int          r;
        logic [7:0]  op;
        logic        md;
        logic [1:0]  kd;
        logic        t;
        sys_rst_i = 1'b1;
        bsr_capture = '0;
        do_reset();
        tst.idle();
        for (r = 0; r < 15; r++) begin
            {op, md, kd} = rows[r];
            ir_load(op, md, 0);
            dr_scan(kd, 38'h2B_6D3C_9E17 ^ {30'h0, op}, 0);
        end
        // pause in mid scan on both paths, contents must survive without recapture
        ir_load(`TAP_OP_CTRL_SCN, 1'b0, 3);
        dr_scan(2'h2, 38'h00_0000_05A3, 6);
        // test instruction loaded, then five TMS highs from Shift-IR
        ir_load(`TAP_OP_EXT_TEST, 1'b1, 0);
        dr_scan(2'h1, 38'h0F_F0F0_1234, 0);
        tst.step(1'b1, 1'b1, t);
        tst.step(1'b1, 1'b1, t);
        tst.step(1'b0, 1'b1, t);
        tst.step(1'b0, 1'b1, t);
        repeat (5) tst.step(1'b1, 1'b0, t);
        check(instruction === `TAP_IR_RST && bsr_latch === `TAP_BSR_RST, "five high steps");
        repeat (3) tst.step(1'b1, 1'b1, t);
        check(bcr_latch === `TAP_BCR_RST && test_mode === 1'b0 && tdo_oe_n === 1'b1, "held reset");
        bsr_exp = `TAP_BSR_RST;
        bcr_exp = `TAP_BCR_RST;
        tst.idle();
        dr_scan(2'h0, 38'h1, 0);
        // second reset in mid run, after a test instruction
        ir_load(`TAP_OP_CLAMP, 1'b1, 0);
        do_reset();
        tst.idle();
        dr_scan(2'h0, 38'h1, 0);
        wrap_up();
    end
endmodule // testbench
